// [rlnc_defines.svh]
`ifndef RLNC_DEFINES_SVH
`define RLNC_DEFINES_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define RLNC_OFF_CTRL    12'h000
`define RLNC_OFF_INSN    12'h004
`define RLNC_OFF_WREG    12'h008
`define RLNC_OFF_BANK    12'h00C
`define RLNC_OFF_STATUS  12'h010
`define RLNC_OFF_FSR     12'h014
`define RLNC_OFF_MADDR   12'h018
`define RLNC_OFF_MDATA   12'h01C
`define RLNC_OFF_RESULT  12'h020

// ----------------------------------------------------------------
// instruction word fields
// ----------------------------------------------------------------
`define RLNC_OPC_HI      15
`define RLNC_OPC_LO      10
`define RLNC_OPCODE      6'h11
`define RLNC_D_BIT       9
`define RLNC_A_BIT       8
`define RLNC_F_HI        7
`define RLNC_F_LO        0

// ----------------------------------------------------------------
// addressing constants
// ----------------------------------------------------------------
`define RLNC_ACC_SPLIT   8'h60
`define RLNC_IDX_MAX     8'h5F
`define RLNC_ACC_LO_BANK 4'h0
`define RLNC_ACC_HI_BANK 4'hF
`define RLNC_MEM_WORDS   4096

// ----------------------------------------------------------------
// status and control bit positions, reset values
// ----------------------------------------------------------------
`define RLNC_ST_C        0
`define RLNC_ST_Z        2
`define RLNC_ST_N        4
`define RLNC_CTRL_EXT    0
`define RLNC_RST_BYTE    8'h00
`define RLNC_RST_BANK    4'h0
`define RLNC_RST_ADDR    12'h000
`define RLNC_RST_WORD    32'h0000_0000

`endif

// [rlnc_pkg.sv]
package rlnc_pkg;

	typedef logic [7:0]  rlnc_byte_type;
	typedef logic [11:0] rlnc_addr_type;
	typedef logic [3:0]  rlnc_bank_type;

	// rotate one bit left, msb wraps into lsb
	function automatic rlnc_byte_type rlnc_rotl(input rlnc_byte_type v);
		return {v[6:0], v[7]};
	endfunction : rlnc_rotl

endpackage : rlnc_pkg

// [rlnc_addr_rot.sv]
`timescale 1ns/100ps
`include "rlnc_defines.svh"

module rlnc_addr_rot
	import rlnc_pkg::*;
(
	input  wire rlnc_byte_type f_i,
	input  wire logic          a_i,
	input  wire rlnc_bank_type bank_i,
	input  wire logic          ext_en_i,
	input  wire rlnc_addr_type fsr_i,
	input  wire rlnc_byte_type operand_i,
	output rlnc_addr_type      eff_addr_o,
	output rlnc_byte_type      result_o,
	output logic               neg_o,
	output logic               zero_o
);

	// ------------------------------------------------------------
	// effective address
	// ------------------------------------------------------------
	always_comb begin
		if (a_i) begin
			eff_addr_o = {bank_i, f_i};
		end else if (ext_en_i && (f_i <= `RLNC_IDX_MAX)) begin
			eff_addr_o = fsr_i + {4'h0, f_i};
		end else if (f_i < `RLNC_ACC_SPLIT) begin
			eff_addr_o = {`RLNC_ACC_LO_BANK, f_i};
		end else begin
			eff_addr_o = {`RLNC_ACC_HI_BANK, f_i};
		end
	end

	// ------------------------------------------------------------
	// rotate and flags
	// ------------------------------------------------------------
	always_comb begin
		result_o = rlnc_rotl(operand_i);
		neg_o    = result_o[7];
		zero_o   = (result_o == `RLNC_RST_BYTE);
	end

endmodule : rlnc_addr_rot

// [rlnc_core.sv]
`timescale 1ns/100ps
`include "rlnc_defines.svh"

module rlnc_core
	import rlnc_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        rst_n_i,
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [11:0] paddr_i,
	input  wire logic [31:0] pwdata_i,
	output logic      [31:0] prdata_o,
	output logic             pready_o,
	output logic             pslverr_o
);

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	logic          ext_q,    ext_d;
	rlnc_byte_type wreg_q,   wreg_d;
	rlnc_bank_type bank_q,   bank_d;
	rlnc_byte_type status_q, status_d;
	rlnc_addr_type fsr_q,    fsr_d;
	rlnc_addr_type maddr_q,  maddr_d;
	rlnc_byte_type res_q,    res_d;
	logic [31:0]   prdata_q, prdata_d;

	rlnc_byte_type mem_q [0:`RLNC_MEM_WORDS-1];
	logic          mem_we;
	rlnc_addr_type mem_wa;
	rlnc_byte_type mem_wd;

	logic          acc_wr;
	logic          setup;
	logic          op_ok;
	logic          exec;
	rlnc_byte_type ins_f;
	logic          ins_a;
	logic          ins_d;
	rlnc_addr_type ea;
	rlnc_byte_type rot;
	logic          rot_n;
	logic          rot_z;
	logic [31:0]   rdata;

	// ------------------------------------------------------------
	// address decode helper
	// ------------------------------------------------------------
	function automatic logic rlnc_mapped(input logic [11:0] a);
		unique case (a)
			`RLNC_OFF_CTRL, `RLNC_OFF_INSN, `RLNC_OFF_WREG,
			`RLNC_OFF_BANK, `RLNC_OFF_STATUS, `RLNC_OFF_FSR,
			`RLNC_OFF_MADDR, `RLNC_OFF_MDATA,
			`RLNC_OFF_RESULT: return 1'b1;
			default:          return 1'b0;
		endcase
	endfunction : rlnc_mapped

	// ------------------------------------------------------------
	// instruction decode
	// ------------------------------------------------------------
	assign acc_wr = psel_i & penable_i & pwrite_i;
	assign setup  = psel_i & ~penable_i;
	assign op_ok  = (pwdata_i[`RLNC_OPC_HI:`RLNC_OPC_LO] == `RLNC_OPCODE);
	assign exec   = acc_wr & (paddr_i == `RLNC_OFF_INSN) & op_ok;
	assign ins_f  = pwdata_i[`RLNC_F_HI:`RLNC_F_LO];
	assign ins_a  = pwdata_i[`RLNC_A_BIT];
	assign ins_d  = pwdata_i[`RLNC_D_BIT];

	rlnc_addr_rot u_addr_rot (
		.f_i        (ins_f),
		.a_i        (ins_a),
		.bank_i     (bank_q),
		.ext_en_i   (ext_q),
		.fsr_i      (fsr_q),
		.operand_i  (mem_q[ea]),
		.eff_addr_o (ea),
		.result_o   (rot),
		.neg_o      (rot_n),
		.zero_o     (rot_z)
	);

	// ------------------------------------------------------------
	// bus answer
	// ------------------------------------------------------------
	assign pready_o  = 1'b1;
	assign pslverr_o = psel_i & penable_i & (~rlnc_mapped(paddr_i) |
		(pwrite_i & (paddr_i == `RLNC_OFF_INSN) & ~op_ok));
	assign prdata_o  = prdata_q;

	always_comb begin
		rdata = `RLNC_RST_WORD;
		unique case (paddr_i)
			`RLNC_OFF_CTRL:   rdata[`RLNC_CTRL_EXT] = ext_q;
			`RLNC_OFF_WREG:   rdata[7:0]  = wreg_q;
			`RLNC_OFF_BANK:   rdata[3:0]  = bank_q;
			`RLNC_OFF_STATUS: rdata[7:0]  = status_q;
			`RLNC_OFF_FSR:    rdata[11:0] = fsr_q;
			`RLNC_OFF_MADDR:  rdata[11:0] = maddr_q;
			`RLNC_OFF_MDATA:  rdata[7:0]  = mem_q[maddr_q];
			`RLNC_OFF_RESULT: rdata[7:0]  = res_q;
			default:          rdata = `RLNC_RST_WORD;
		endcase
	end

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		ext_d    = ext_q;
		wreg_d   = wreg_q;
		bank_d   = bank_q;
		status_d = status_q;
		fsr_d    = fsr_q;
		maddr_d  = maddr_q;
		res_d    = res_q;
		mem_we   = 1'b0;
		mem_wa   = ea;
		mem_wd   = rot;
		prdata_d = prdata_q;
		// read data is latched in the setup cycle
		if (setup && !pwrite_i) begin
			prdata_d = rdata;
		end
		if (acc_wr) begin
			unique case (paddr_i)
				`RLNC_OFF_CTRL:   ext_d    = pwdata_i[`RLNC_CTRL_EXT];
				`RLNC_OFF_WREG:   wreg_d   = pwdata_i[7:0];
				`RLNC_OFF_BANK:   bank_d   = pwdata_i[3:0];
				`RLNC_OFF_STATUS: status_d = pwdata_i[7:0];
				`RLNC_OFF_FSR:    fsr_d    = pwdata_i[11:0];
				`RLNC_OFF_MADDR:  maddr_d  = pwdata_i[11:0];
				`RLNC_OFF_MDATA: begin
					mem_we = 1'b1;
					mem_wa = maddr_q;
					mem_wd = pwdata_i[7:0];
				end
				default: begin
				end
			endcase
		end
		if (exec) begin
			res_d = rot;
			status_d[`RLNC_ST_N] = rot_n;
			status_d[`RLNC_ST_Z] = rot_z;
			if (ins_d) begin
				mem_we = 1'b1;
				mem_wa = ea;
				mem_wd = rot;
			end else begin
				wreg_d = rot;
			end
		end
	end

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			ext_q    <= 1'b0;
			wreg_q   <= `RLNC_RST_BYTE;
			bank_q   <= `RLNC_RST_BANK;
			status_q <= `RLNC_RST_BYTE;
			fsr_q    <= `RLNC_RST_ADDR;
			maddr_q  <= `RLNC_RST_ADDR;
			res_q    <= `RLNC_RST_BYTE;
			prdata_q <= `RLNC_RST_WORD;
		end else begin
			ext_q    <= ext_d;
			wreg_q   <= wreg_d;
			bank_q   <= bank_d;
			status_q <= status_d;
			fsr_q    <= fsr_d;
			maddr_q  <= maddr_d;
			res_q    <= res_d;
			prdata_q <= prdata_d;
		end
	end

	// data memory has no reset
	always_ff @(posedge clk_i) begin
		if (mem_we) begin
			mem_q[mem_wa] <= mem_wd;
		end
	end

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	sequence s_exec_w;
		exec && !ins_d;
	endsequence

	sequence s_exec_f;
		exec && ins_d;
	endsequence

	property p_rotate;
		@(posedge clk_i) disable iff (!rst_n_i)
		exec |=> res_q == {$past(mem_q[ea][6:0]), $past(mem_q[ea][7])};
	endproperty
	a_rotate: assert property (p_rotate)
		else $error("rotated result wrong");

	property p_dest_w;
		@(posedge clk_i) disable iff (!rst_n_i)
		s_exec_w |=> (wreg_q == $past(rot)) && (res_q == wreg_q);
	endproperty
	a_dest_w: assert property (p_dest_w)
		else $error("working register not written");

	property p_dest_f;
		@(posedge clk_i) disable iff (!rst_n_i)
		s_exec_f |=> (mem_q[$past(ea)] == $past(rot)) && $stable(wreg_q);
	endproperty
	a_dest_f: assert property (p_dest_f)
		else $error("file register not written back");

	property p_access_bank;
		@(posedge clk_i) disable iff (!rst_n_i)
		exec && !ins_a && !(ext_q && ins_f <= `RLNC_IDX_MAX) |->
			ea == ((ins_f < `RLNC_ACC_SPLIT) ?
			{`RLNC_ACC_LO_BANK, ins_f} : {`RLNC_ACC_HI_BANK, ins_f});
	endproperty
	a_access_bank: assert property (p_access_bank)
		else $error("access bank address wrong");

	property p_banked;
		@(posedge clk_i) disable iff (!rst_n_i)
		exec && ins_a |-> ea == {bank_q, ins_f};
	endproperty
	a_banked: assert property (p_banked)
		else $error("banked address wrong");

	property p_indexed;
		@(posedge clk_i) disable iff (!rst_n_i)
		exec && !ins_a && ext_q && (ins_f <= `RLNC_IDX_MAX) |->
			ea == rlnc_addr_type'(fsr_q + {4'h0, ins_f});
	endproperty
	a_indexed: assert property (p_indexed)
		else $error("indexed address wrong");

	property p_flags;
		@(posedge clk_i) disable iff (!rst_n_i)
		exec |=> (status_q[`RLNC_ST_N] == res_q[7]) &&
			(status_q[`RLNC_ST_Z] == (res_q == `RLNC_RST_BYTE)) &&
			(status_q[`RLNC_ST_C] == $past(status_q[`RLNC_ST_C]));
	endproperty
	a_flags: assert property (p_flags)
		else $error("status flags wrong");

	property p_one_cycle;
		@(posedge clk_i) disable iff (!rst_n_i)
		exec |-> (pready_o && !pslverr_o) ##1 (res_q == $past(rot));
	endproperty
	a_one_cycle: assert property (p_one_cycle)
		else $error("instruction not done in one cycle");

endmodule : rlnc_core

// [rotate_left_no_carry_exec_test.sv]
`timescale 1ns/100ps
`include "rlnc_defines.svh"

module rotate_left_no_carry_exec_test;
	import rlnc_pkg::*;

	logic        clk_i;
	logic        rst_n_i;
	logic        psel_i;
	logic        penable_i;
	logic        pwrite_i;
	logic [11:0] paddr_i;
	logic [31:0] pwdata_i;
	logic [31:0] prdata_o;
	logic        pready_o;
	logic        pslverr_o;
	int          bad_count;
	int          checks;
	logic [31:0] rd;
	logic        err;

	rlnc_core dut_u (
		.clk_i     (clk_i),
		.rst_n_i   (rst_n_i),
		.psel_i    (psel_i),
		.penable_i (penable_i),
		.pwrite_i  (pwrite_i),
		.paddr_i   (paddr_i),
		.pwdata_i  (pwdata_i),
		.prdata_o  (prdata_o),
		.pready_o  (pready_o),
		.pslverr_o (pslverr_o)
	);

	always #20 clk_i = ~clk_i;

	// ----------------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen,
				exp);
		end
	endtask : check

	task automatic finish_test;
		$display("mismatches %0d, comparisons %0d", bad_count, checks);
		if (bad_count == 0 && checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : finish_test

	task automatic apb(input logic wr, input logic [11:0] addr,
		input logic [31:0] wd);
		@(posedge clk_i);
		psel_i   <= 1'b1;
		penable_i <= 1'b0;
		pwrite_i <= wr;
		paddr_i  <= addr;
		pwdata_i <= wd;
		@(posedge clk_i);
		penable_i <= 1'b1;
		// the wait for ready ends at the first edge where pready_o is 1
		do begin
			@(posedge clk_i);
		end while (pready_o !== 1'b1);
		rd  = prdata_o;
		err = pslverr_o;
		psel_i    <= 1'b0;
		penable_i <= 1'b0;
	endtask : apb

	// one rotation through the instruction register, then read back
	task automatic do_rot(input logic [11:0] maddr, input logic [7:0] val,
		input logic d, input logic a, input logic [7:0] f);
		logic [7:0] res;
		logic       c;
		res = {val[6:0], val[7]};
		c   = val[3];
		apb(1'b1, `RLNC_OFF_MADDR, {20'h0, maddr});
		apb(1'b1, `RLNC_OFF_MDATA, {24'h0, val});
		apb(1'b1, `RLNC_OFF_WREG, 32'h0000_005A);
		apb(1'b1, `RLNC_OFF_STATUS, {31'h0, c});
		apb(1'b1, `RLNC_OFF_INSN, {16'h0, 6'h11, d, a, f});
		check({31'h0, err}, 32'h0000_0000);
		apb(1'b0, `RLNC_OFF_RESULT, 32'h0);
		check(rd, {24'h0, res});
		apb(1'b0, `RLNC_OFF_MDATA, 32'h0);
		check(rd, {24'h0, d ? res : val});
		apb(1'b0, `RLNC_OFF_WREG, 32'h0);
		check(rd, {24'h0, d ? 8'h5A : res});
		apb(1'b0, `RLNC_OFF_STATUS, 32'h0);
		check(rd, {27'h0, res[7], 1'b0, res == 8'h00, 1'b0, c});
	endtask : do_rot

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic reset_values;
		apb(1'b0, `RLNC_OFF_RESULT, 32'h0);
		check(rd, 32'h0000_0000);
		apb(1'b0, `RLNC_OFF_WREG, 32'h0);
		check(rd, 32'h0000_0000);
		apb(1'b0, 12'h040, 32'h0);
		check({31'h0, err}, 32'h0000_0001);
	endtask : reset_values

	task automatic banked_access;
		apb(1'b1, `RLNC_OFF_BANK, 32'h0000_0001);
		do_rot(12'h134, 8'hAB, 1'b1, 1'b1, 8'h34);
		apb(1'b1, `RLNC_OFF_BANK, 32'h0000_0003);
		do_rot(12'h3F0, 8'h80, 1'b0, 1'b1, 8'hF0);
	endtask : banked_access

	task automatic access_bank;
		// low and high halves of the access bank
		apb(1'b1, `RLNC_OFF_CTRL, 32'h0000_0000);
		do_rot(12'h010, 8'h00, 1'b1, 1'b0, 8'h10);
		do_rot(12'hF70, 8'hC0, 1'b0, 1'b0, 8'h70);
		do_rot(12'h05F, 8'h11, 1'b1, 1'b0, 8'h5F);
	endtask : access_bank

	task automatic indexed_offset;
		apb(1'b1, `RLNC_OFF_CTRL, 32'h0000_0001);
		apb(1'b1, `RLNC_OFF_FSR, 32'h0000_0200);
		do_rot(12'h25F, 8'h41, 1'b1, 1'b0, 8'h5F);
		do_rot(12'h200, 8'hFF, 1'b0, 1'b0, 8'h00);
		do_rot(12'hF60, 8'h7F, 1'b1, 1'b0, 8'h60);
		apb(1'b1, `RLNC_OFF_BANK, 32'h0000_0002);
		do_rot(12'h205, 8'h3C, 1'b1, 1'b1, 8'h05);
	endtask : indexed_offset

	task automatic bad_opcode;
		apb(1'b0, `RLNC_OFF_RESULT, 32'h0);
		check(rd, 32'h0000_0078);
		err = 1'b0;
		apb(1'b1, `RLNC_OFF_INSN, {16'h0, 6'h12, 2'b11, 8'h05});
		check({31'h0, err}, 32'h0000_0001);
		apb(1'b0, `RLNC_OFF_RESULT, 32'h0);
		check(rd, 32'h0000_0078);
	endtask : bad_opcode

	// ----------------------------------------------------------------
	// main sequence and watchdog
	// ----------------------------------------------------------------
	initial begin
		clk_i     = 1'b0;
		rst_n_i   = 1'b0;
		psel_i    = 1'b0;
		penable_i = 1'b0;
		pwrite_i  = 1'b0;
		paddr_i   = 12'h000;
		pwdata_i  = 32'h0000_0000;
		bad_count = 0;
		checks    = 0;
		repeat (20) @(posedge clk_i);
		rst_n_i <= 1'b1;
		reset_values();
		banked_access();
		access_bank();
		indexed_offset();
		bad_opcode();
		finish_test();
	end

	initial begin
		repeat (5000) @(posedge clk_i);
		bad_count++;
		finish_test();
	end

endmodule : rotate_left_no_carry_exec_test
